/* rtl/odp_pin.v */
// one open-drain pin: pull-down control and read-back selection
`timescale 1ns/10ps
`default_nettype none
module odp_pin #(
  parameter IS_BIAS = 0
) (
  input  wire clock_i,
  input  wire rst_n_i,
  input  wire latch_i,
  input  wire bias_sel_i,
  input  wire float_i,
  input  wire pin_i,
  output wire pd_en_nxt_o,
  output wire rd_o
);
  wire pin_s;
  wire bias_mode;
  odp_sync #(.RST_VAL(1'b1)) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i (pin_i),
    .sync_o  (pin_s)
  );
  // bias select low claims the pin (see RL6)
  assign bias_mode = (IS_BIAS != 0) && !bias_sel_i;
  // latch 0 pulls low unless floated by stop or bias (see RL2) (see RL11) (see RL12)
  assign pd_en_nxt_o = !latch_i && !float_i && !bias_mode;
  // driving: latch; released: pin level; bias: 0 (see RL3) (see RL4) (see RL7)
  assign rd_o = bias_mode ? 1'b0 : (!latch_i ? 1'b0 : pin_s);
endmodule
`default_nettype wire

/* rtl/odp_port.v */
// four-bit open-drain port with latch register, bias select and stop handling
`include "odp_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module odp_port (
  input  wire                     clock_i,
  input  wire                     arst_n_i,
  input  wire [`ODP_ADDR_W-1:0]   addr_i,
  input  wire [`ODP_DATA_W-1:0]   wdata_i,
  input  wire                     wr_i,
  input  wire                     rd_i,
  input  wire [`ODP_CMD_W-1:0]    bit_cmd_i,
  input  wire [1:0]               bit_idx_i,
  input  wire [`ODP_PIN_N-1:0]    pin_i,
  output reg  [`ODP_DATA_W-1:0]   rdata_o,
  output reg  [`ODP_PIN_N-1:0]    pin_o,
  output reg  [`ODP_PIN_N-1:0]    pin_oe_o,
  output reg                      bias_sel_o,
  output reg                      stop_float_o
);
  reg                    rst_a_r;
  reg                    rst_n_r;
  reg [`ODP_PIN_N-1:0]   latch_r;
  reg [`ODP_PIN_N-1:0]   latch_nxt;
  reg [`ODP_DATA_W-1:0]  ctrl_r;
  wire [`ODP_PIN_N-1:0]  pd_nxt;
  wire [`ODP_PIN_N-1:0]  rd_bits;
  wire                   stop_float;
  wire                   wr_latch;
  wire [`ODP_PIN_N-1:0]  onehot;
  genvar g;

  // reset release through two flops
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_a_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n_r <= rst_a_r;
    end
  end

  // stop mode floats pins only when float select is set (see RL11) (see RL13)
  assign stop_float = ctrl_r[`ODP_CTRL_STOP_BIT] & ctrl_r[`ODP_CTRL_SPL_BIT];
  assign wr_latch   = wr_i && (addr_i == `ODP_LATCH_OFS);
  assign onehot     = 4'h1 << bit_idx_i;

  // write loads latch; bit ops modify latch, not pins (see RL2) (see RL5)
  always @* begin
    latch_nxt = latch_r;
    if (wr_latch) begin
      latch_nxt = wdata_i[`ODP_PIN_N-1:0];
    end else if (bit_cmd_i == `ODP_CMD_SET) begin
      latch_nxt = latch_r | onehot;
    end else if (bit_cmd_i == `ODP_CMD_CLR) begin
      latch_nxt = latch_r & ~onehot;
    end
  end

  // reset: latch all ones, bias select 0 (see RL9) (see RL10)
  always @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      latch_r <= `ODP_LATCH_RST;
      ctrl_r  <= `ODP_CTRL_RST;
    end else begin
      latch_r <= latch_nxt;
      if (wr_i && (addr_i == `ODP_CTRL_OFS)) begin
        ctrl_r <= {5'h00, wdata_i[2:0]};
      end
    end
  end

  generate
    for (g = 0; g < `ODP_PIN_N; g = g + 1) begin : g_pin
      odp_pin #(
        .IS_BIAS((g == `ODP_BIAS_LO) || (g == `ODP_BIAS_HI))
      ) u_pin (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_r),
        .latch_i     (latch_r[g]),
        .bias_sel_i  (ctrl_r[`ODP_CTRL_BIAS_BIT]),
        .float_i     (stop_float),
        .pin_i       (pin_i[g]),
        .pd_en_nxt_o (pd_nxt[g]),
        .rd_o        (rd_bits[g])
      );
    end
  endgenerate

  // outputs registered; upper bits read zero (see RL1)
  always @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_o      <= 8'h00;
      pin_o        <= 4'h0;
      pin_oe_o     <= 4'h0;
      bias_sel_o   <= 1'b0;
      stop_float_o <= 1'b0;
    end else begin
      pin_o        <= 4'h0;
      pin_oe_o     <= pd_nxt;
      bias_sel_o   <= ctrl_r[`ODP_CTRL_BIAS_BIT];
      stop_float_o <= stop_float;
      if (rd_i && (addr_i == `ODP_LATCH_OFS)) begin
        rdata_o <= {4'h0, rd_bits};
      end else if (rd_i && (addr_i == `ODP_CTRL_OFS)) begin
        rdata_o <= ctrl_r;
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/odp_regs.vh */
// register map, field positions and reset values for the open-drain port
// Operation
// RL1: four open-drain pins map to latch bits 0..3; bits 7..4 unused.
// RL2: write at 000C loads latch; 0 pulls pin low, 1 releases it.
// RL3: pin driving output reads back its latch value.
// RL4: released pin used as input reads sampled pin level.
// RL5: bit set/clear read the latch, other latch bits stay unchanged.
// RL6: bias select 0 makes pins two and three bias inputs only.
// RL7: bias-input pins read as 0.
// RL8: software writes 1 to latch bits two and three when using bias.
// RL9: reset loads all four latch bits with 1, all pins float.
// RL10: reset clears bias select, so pins two and three are bias inputs.
// RL11: stop mode with float select 1 forces all pull-downs off.
// RL12: bias pins in stop mode hold their pre-stop voltage.
// RL13: otherwise pins keep working as configured.
`ifndef ODP_REGS_VH
`define ODP_REGS_VH
`define ODP_ADDR_W        8
`define ODP_DATA_W        8
`define ODP_PIN_N         4
`define ODP_LATCH_OFS     8'h0C
`define ODP_CTRL_OFS      8'h0D
`define ODP_LATCH_RST     4'hF
`define ODP_CTRL_RST      8'h00
`define ODP_CTRL_BIAS_BIT 0
`define ODP_CTRL_SPL_BIT  1
`define ODP_CTRL_STOP_BIT 2
`define ODP_CMD_W         2
`define ODP_CMD_NONE      2'h0
`define ODP_CMD_SET       2'h1
`define ODP_CMD_CLR       2'h2
`define ODP_BIAS_LO       2
`define ODP_BIAS_HI       3
`endif

/* rtl/odp_sync.v */
// three-stage synchroniser for pin inputs, change taken when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module odp_sync #(
  parameter RST_VAL = 1'b1
) (
  input  wire clock_i,
  input  wire rst_n_i,
  input  wire async_i,
  output reg  sync_o
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r   <= RST_VAL;
      s2_r   <= RST_VAL;
      s3_r   <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        sync_o <= s3_r;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/odp_port_asserts.sv */
// checker for the open-drain port
`timescale 1ns/10ps
`default_nettype none
module odp_port_chk (
  input wire logic       clock_i,
  input wire logic       arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [1:0] bit_cmd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe_o,
  input wire logic       bias_sel_o,
  input wire logic       stop_float_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  wire rd_lat = rd_i && addr_i == 8'h0C && !wr_i;
  AST_UPPER: assert property (rdata_o[7:4] == 4'h0) else $error("upper");
  AST_PIN_LOW: assert property (pin_o == 4'h0) else $error("pin high");
  AST_WR_OE: assert property (wr_i && addr_i == 8'h0C && bias_sel_o && !stop_float_o
    ##1 !wr_i && bit_cmd_i == 2'h0 |-> ##1 pin_oe_o[1:0] == ~$past(wdata_i[1:0], 2))
    else $error("pull-down");
  AST_RD_LATCH: assert property (rd_lat && pin_oe_o[0] && !$past(wr_i)
    && $past(bit_cmd_i) == 2'h0 |=> !rdata_o[0]) else $error("latch read");
  AST_BIAS_RD: assert property (rd_lat && !bias_sel_o && !$past(wr_i) && !$past(wr_i, 2)
    |=> rdata_o[3:2] == 2'h0) else $error("bias read");
  AST_BIAS_OFF: assert property (!bias_sel_o && !$past(bias_sel_o)
    |-> pin_oe_o[3:2] == 2'h0) else $error("bias pulled");
  AST_FLOAT: assert property (stop_float_o && $past(stop_float_o)
    |-> pin_oe_o == 4'h0) else $error("stop pulled");
  AST_RST: assert property ($rose(arst_n_i) |-> pin_oe_o == 4'h0 && !bias_sel_o)
    else $error("reset state");
  cover property (wr_i && addr_i == 8'h0C);
  cover property (stop_float_o);
  cover property (rd_i && !bias_sel_o);
endmodule
bind odp_port odp_port_chk odp_port_chk_i (.*);
`default_nettype wire

/* verification/test_odp_port.sv */
// bench for the open-drain port
`timescale 1ns/10ps
`default_nettype none
module test_odp_port;
  logic       clock_i = '0, arst_n_i = '0, wr_i = '0, rd_i = '0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00;
  logic [1:0] bit_cmd_i = 2'h0, bit_idx_i = 2'h0;
  logic [3:0] ext = 4'hF;
  wire  [7:0] rdata_o;
  wire  [3:0] pin_o, pin_oe_o;
  wire        bias_sel_o, stop_float_o;
  int         fails = 0, n_compared = 0;
  odp_port odp_port_i (.clock_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .bit_cmd_i,
    .bit_idx_i, .pin_i(ext & ~pin_oe_o), .rdata_o, .pin_o, .pin_oe_o, .bias_sel_o,
    .stop_float_o);
  task automatic chk(input logic [7:0] g, e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge clock_i) wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clock_i) {rd_i, addr_i} <= {1'b1, a};
    @(posedge clock_i) rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  task automatic bop(input logic [1:0] c, i);
    @(posedge clock_i) {bit_cmd_i, bit_idx_i} <= {c, i};
    @(posedge clock_i) bit_cmd_i <= 2'h0;
  endtask
  task automatic idle;
    repeat (6) @(posedge clock_i);
  endtask
  task automatic stop_test;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic t_main;
    rd(8'h0C, 8'h03);
    chk({3'h0, bias_sel_o, pin_oe_o}, 8'h00);
    $display("reset test done");
    wr(8'h0D, 8'h01);
    wr(8'h0C, 8'hFE);
    idle;
    chk({4'h0, pin_oe_o}, 8'h01);
    rd(8'h0C, 8'h0E);
    @(posedge clock_i) ext <= 4'h0;
    idle;
    rd(8'h0C, 8'h00);
    @(posedge clock_i) ext <= 4'hF;
    $display("gpio test done");
  endtask
  task automatic t_bits;
    bop(2'h2, 2'h2);
    bop(2'h1, 2'h0);
    idle;
    rd(8'h0C, 8'h0B);
    $display("bit test done");
  endtask
  task automatic t_stop;
    wr(8'h0D, 8'h07);
    rd(8'h0D, 8'h07);
    idle;
    chk({3'h0, stop_float_o, pin_oe_o}, 8'h10);
    wr(8'h0D, 8'h05);
    idle;
    chk({4'h0, pin_oe_o}, 8'h04);
    rd(8'h20, 8'h00);
    wr(8'h0C, 8'h0F);
    wr(8'h0D, 8'h00);
    idle;
    chk({4'h0, pin_oe_o}, 8'h00);
    rd(8'h0C, 8'h03);
    $display("stop test done");
  endtask
  initial forever #5 clock_i = ~clock_i;
  initial begin
    repeat (4) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_main;
    t_bits;
    t_stop;
    stop_test;
  end
  initial begin
    #20000;
    fails++;
    stop_test;
  end
endmodule
`default_nettype wire
